// [pkg/spm_pkg.sv]
// Package: register map, field positions, reset values and timing for the serial port unit
package spm_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STAT_OFF   = 8'h04;
   localparam logic [7:0] TXDATA_OFF = 8'h08;
   localparam logic [7:0] RXDATA_OFF = 8'h0c;
   localparam logic [7:0] CLKDIV_OFF = 8'h10;
   // Control register fields
   localparam int CTRL_PORT_EN_BIT   = 0;
   localparam int CTRL_MASTER_EN_BIT = 1;
   localparam int CTRL_MODE_LO_BIT   = 2;
   localparam int CTRL_MODE_HI_BIT   = 3;
   // Status register fields; done and fault are write one to clear, busy and transmit full are read only
   localparam int STAT_DONE_BIT      = 0;
   localparam int STAT_FAULT_BIT     = 1;
   localparam int STAT_BUSY_BIT      = 2;
   localparam int STAT_TXFULL_BIT    = 3;
   // Select pin mode codes
   localparam logic [1:0] MODE_3WIRE = 2'b00;
   localparam logic [1:0] MODE_4IN   = 2'b01;
   // Reset values
   localparam logic [3:0] CTRL_RST   = 4'h4;
   localparam logic [7:0] CLKDIV_RST = 8'h03;
   // Least select setup before first clock edge
   localparam int SEL_SETUP_CYC      = 2;
   typedef enum logic [1:0] {SPM_IDLE, SPM_LOAD, SPM_SHIFT} spm_state_t;
endpackage

// [pkg/spm_shift_if.sv]
// Interface: byte exchange between the control logic and the shift engine
`timescale 1ns/1ps
interface spm_shift_if;
   logic       start;
   logic [7:0] tx_byte;
   logic       done;
   logic [7:0] rx_byte;
   logic       busy;
   modport ctrl (output start, output tx_byte, input done, input rx_byte, input busy);
   modport eng  (input start, input tx_byte, output done, output rx_byte, output busy);
endinterface

// [rtl/spm_shift.sv]
// Shift engine: eight-bit full-duplex shifter for master and slave roles
`timescale 1ns/1ps
module spm_shift #(
   parameter int DIV_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             enable,
   input  wire logic             master,
   input  wire logic             selected,
   input  wire logic             sel_fall,
   input  wire logic [DIV_W-1:0] div,
   input  wire logic             sck_in,
   input  wire logic             din,
   output logic                  sck_out,
   output logic                  dout,
   spm_shift_if.eng              sif
);
   // Divider must fit the low half of one register word
   if (DIV_W < 1 || DIV_W > 16) begin : g_div_chk
      $error("spm_shift: DIV_W out of range");
   end

   typedef struct packed {
      spm_pkg::spm_state_t st;
      logic [7:0]          sh;
      logic [2:0]          cnt;
      logic [DIV_W-1:0]    dcnt;
      logic                sck;
      logic                sck_d;
      logic                done;
      logic [7:0]          rx;
   } spm_eng_t;

   spm_eng_t s_r, s_nxt;
   logic     rise;
   logic     fall;

   assign rise = sck_in & ~s_r.sck_d;
   assign fall = ~sck_in & s_r.sck_d;

   // Sample on rising edge, shift on falling edge (mode 0 timing)
   always_comb begin
      s_nxt       = s_r;
      s_nxt.done  = 1'b0;
      s_nxt.sck_d = sck_in;
      if (!enable) begin
         s_nxt.st  = spm_pkg::SPM_IDLE;
         s_nxt.cnt = 3'h0;
         s_nxt.sck = 1'b0;
      end else if (master) begin
         unique case (s_r.st)
            spm_pkg::SPM_IDLE: begin
               s_nxt.sck = 1'b0;
               if (sif.start) begin
                  s_nxt.sh   = sif.tx_byte;
                  s_nxt.cnt  = 3'h0;
                  s_nxt.dcnt = div;
                  s_nxt.st   = spm_pkg::SPM_SHIFT;
               end
            end
            spm_pkg::SPM_LOAD,
            spm_pkg::SPM_SHIFT: begin
               if (s_r.dcnt != '0) begin
                  s_nxt.dcnt = s_r.dcnt - 1'b1;
               end else begin
                  s_nxt.dcnt = div;
                  s_nxt.sck  = ~s_r.sck;
                  if (!s_r.sck) begin
                     // Rising edge only samples, so data out holds steady across the far side's sample
                     s_nxt.rx[0] = din;
                  end else begin
                     s_nxt.sh  = {s_r.sh[6:0], s_r.rx[0]};
                     s_nxt.cnt = s_r.cnt + 3'h1;
                     if (s_r.cnt == 3'h7) begin
                        s_nxt.done = 1'b1;
                        s_nxt.rx   = {s_r.sh[6:0], s_r.rx[0]};
                        s_nxt.st   = spm_pkg::SPM_IDLE;
                     end
                  end
               end
            end
            default: s_nxt.st = spm_pkg::SPM_IDLE;
         endcase
      end else begin
         s_nxt.sck = 1'b0;
         if (sel_fall) begin
            s_nxt.cnt = 3'h0;
         end
         if (sif.start && s_r.cnt == 3'h0 && !s_r.sck_d) begin
            s_nxt.sh = sif.tx_byte;
         end
         // Unselected slave ignores clock activity
         if (selected && rise) begin
            s_nxt.rx[0] = din;
         end
         if (selected && fall) begin
            s_nxt.sh  = {s_r.sh[6:0], s_r.rx[0]};
            s_nxt.cnt = s_r.cnt + 3'h1;
            if (s_r.cnt == 3'h7) begin
               s_nxt.done = 1'b1;
               s_nxt.rx   = {s_r.sh[6:0], s_r.rx[0]};
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign sck_out  = s_r.sck;
   assign dout     = s_r.sh[7];
   assign sif.done = s_r.done;
   assign sif.rx_byte = s_r.rx;
   assign sif.busy = (s_r.st != spm_pkg::SPM_IDLE) || (!master && s_r.cnt != 3'h0);
endmodule

// [rtl/spm_port.sv]
// Serial port unit top: AXI4-Lite registers, pin direction control and select handling
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module spm_port #(
   parameter int DIV_W = 8
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        ce,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial pins, enables low while driving
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_n,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_n,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_n,
   input  wire logic        sel_n_i,
   output logic             sel_n_o,
   output logic             sel_n_oe_n,
   output logic             sel_pin_routed
);
   // Divider must fit the low half of one register word
   if (DIV_W < 1 || DIV_W > 16) begin : g_div_chk
      $error("spm_port: DIV_W out of range");
   end

   typedef struct packed {
      logic             aw_got;
      logic [7:0]       aw_addr;
      logic             w_got;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [3:0]       ctrl;
      logic             done_f;
      logic             fault_f;
      logic [7:0]       txbuf;
      logic             txfull;
      logic             start;
      logic [7:0]       rxbuf;
      logic [DIV_W-1:0] div;
      logic [1:0]       sck_s;
      logic [1:0]       mosi_s;
      logic [1:0]       miso_s;
      logic [1:0]       sel_s;
      logic             sel_d;
      logic             mosi_o;
      logic             mosi_oe_n;
      logic             miso_o;
      logic             miso_oe_n;
      logic             sck_o;
      logic             sck_oe_n;
      logic             sel_o;
      logic             sel_oe_n;
      logic             routed;
   } spm_top_t;

   spm_top_t    r, n;
   spm_shift_if sif ();
   logic        en;
   logic        mst;
   logic        selected;
   logic        sel_fall;
   logic        eng_sck;
   logic        eng_dout;
   logic        wr_go;
   logic        rd_go;

   assign en  = r.ctrl[spm_pkg::CTRL_PORT_EN_BIT];
   assign mst = r.ctrl[spm_pkg::CTRL_MASTER_EN_BIT];
   // Only the second synchroniser stage feeds logic
   assign sel_fall = r.sel_d & ~r.sel_s[1];
   // Three-line slave is always selected
   assign selected = (r.ctrl[3:2] == spm_pkg::MODE_3WIRE) ? 1'b1 : ~r.sel_s[1];

   spm_shift #(.DIV_W(DIV_W)) u_eng (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .ce       (ce),
      .enable   (en),
      .master   (mst),
      .selected (selected),
      .sel_fall (sel_fall & (r.ctrl[3:2] == spm_pkg::MODE_4IN)),
      .div      (r.div),
      .sck_in   (r.sck_s[1]),
      .din      (mst ? r.miso_s[1] : r.mosi_s[1]),
      .sck_out  (eng_sck),
      .dout     (eng_dout),
      .sif      (sif)
   );

   assign sif.start   = r.start;
   assign sif.tx_byte = r.txbuf;
   assign wr_go = r.aw_got && r.w_got && !r.bvalid;
   assign rd_go = s_axi_arvalid && !r.rvalid;

   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) res[i*8 +: 8] = d[i*8 +: 8];
      end
      return res;
   endfunction

   // Bus handling, register effects and pin drive
   always_comb begin
      logic [31:0] wv;
      wv = '0;
      n = r;
      n.sck_s  = {r.sck_s[0], sck_i};
      n.mosi_s = {r.mosi_s[0], mosi_i};
      n.miso_s = {r.miso_s[0], miso_i};
      n.sel_s  = {r.sel_s[0], sel_n_i};
      n.sel_d  = r.sel_s[1];
      n.start  = 1'b0;
      // Address and data taken in either order
      if (s_axi_awvalid && !r.aw_got) begin
         n.aw_got  = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got) begin
         n.w_got  = 1'b1;
         n.w_data = s_axi_wdata;
         n.w_strb = s_axi_wstrb;
      end
      // Address and data slots stay full until the response is taken, so no write overtakes it
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
      end
      if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
      // Engine events; hardware set wins over software clear below
      if (sif.done) begin
         n.rxbuf = sif.rx_byte;
      end
      // Hand transmit buffer to the idle shifter
      if (r.txfull && !sif.busy && !r.start && en) begin
         n.start  = 1'b1;
         n.txfull = 1'b0;
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp  = 2'b00;
         unique case (r.aw_addr)
            spm_pkg::CTRL_OFF: begin
               wv = wmask({28'h0, r.ctrl}, r.w_data, r.w_strb);
               n.ctrl = wv[3:0];
            end
            spm_pkg::STAT_OFF: begin
               if (r.w_strb[0] && r.w_data[spm_pkg::STAT_DONE_BIT]) n.done_f = 1'b0;
               if (r.w_strb[0] && r.w_data[spm_pkg::STAT_FAULT_BIT]) n.fault_f = 1'b0;
            end
            spm_pkg::TXDATA_OFF: begin
               // Write while buffer full is dropped
               if (r.w_strb[0] && !r.txfull) begin
                  n.txbuf  = r.w_data[7:0];
                  n.txfull = 1'b1;
               end
            end
            spm_pkg::CLKDIV_OFF: begin
               wv = wmask({{(32-DIV_W){1'b0}}, r.div}, r.w_data, r.w_strb);
               n.div = wv[DIV_W-1:0];
            end
            default: n.bresp = 2'b10;
         endcase
      end
      if (sif.done) n.done_f = 1'b1;
      // Multi-master: falling select drops master and port enables
      if (en && mst && r.ctrl[3:2] == spm_pkg::MODE_4IN && sel_fall) begin
         n.fault_f = 1'b1;
         n.ctrl[spm_pkg::CTRL_MASTER_EN_BIT] = 1'b0;
         n.ctrl[spm_pkg::CTRL_PORT_EN_BIT]   = 1'b0;
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp  = 2'b00;
         unique case (s_axi_araddr)
            spm_pkg::CTRL_OFF:   n.rdata = {28'h0, r.ctrl};
            spm_pkg::STAT_OFF:   n.rdata = {28'h0, r.txfull, sif.busy, r.fault_f, r.done_f};
            spm_pkg::TXDATA_OFF: n.rdata = {24'h0, r.txbuf};
            spm_pkg::RXDATA_OFF: n.rdata = {24'h0, r.rxbuf};
            spm_pkg::CLKDIV_OFF: n.rdata = {{(32-DIV_W){1'b0}}, r.div};
            default: begin
               n.rdata = 32'h0;
               n.rresp = 2'b10;
            end
         endcase
      end
      // Pin directions follow role, enable and select
      n.mosi_o    = eng_dout;
      n.mosi_oe_n = ~(en & mst);
      n.sck_o     = eng_sck;
      n.sck_oe_n  = ~(en & mst);
      n.miso_o    = eng_dout;
      n.miso_oe_n = ~(en & ~mst & selected);
      n.sel_o     = r.ctrl[spm_pkg::CTRL_MODE_LO_BIT];
      n.sel_oe_n  = ~r.ctrl[spm_pkg::CTRL_MODE_HI_BIT];
      n.routed    = (r.ctrl[3:2] != spm_pkg::MODE_3WIRE);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r           <= '0;
         r.ctrl      <= spm_pkg::CTRL_RST;
         r.div       <= DIV_W'(spm_pkg::CLKDIV_RST);
         r.sel_s     <= 2'b11;
         r.sel_d     <= 1'b1;
         r.mosi_oe_n <= 1'b1;
         r.miso_oe_n <= 1'b1;
         r.sck_oe_n  <= 1'b1;
         r.sel_o     <= 1'b1;
         r.sel_oe_n  <= 1'b1;
         r.routed    <= 1'b1;
      end else if (ce) begin
         r <= n;
      end
   end

   assign s_axi_awready  = ~r.aw_got;
   assign s_axi_wready   = ~r.w_got;
   assign s_axi_bvalid   = r.bvalid;
   assign s_axi_bresp    = r.bresp;
   assign s_axi_arready  = ~r.rvalid;
   assign s_axi_rvalid   = r.rvalid;
   assign s_axi_rdata    = r.rdata;
   assign s_axi_rresp    = r.rresp;
   assign mosi_o         = r.mosi_o;
   assign mosi_oe_n      = r.mosi_oe_n;
   assign miso_o         = r.miso_o;
   assign miso_oe_n      = r.miso_oe_n;
   assign sck_o          = r.sck_o;
   assign sck_oe_n       = r.sck_oe_n;
   assign sel_n_o        = r.sel_o;
   assign sel_n_oe_n     = r.sel_oe_n;
   assign sel_pin_routed = r.routed;
endmodule

// [sim/spm_port_asserts.sv]
// Checker: pin direction, select handling and register bus timing at the port unit's pins
`timescale 1ns/1ps
module spm_port_asserts (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        mosi_oe_n,
   input wire logic        miso_oe_n,
   input wire logic        sck_oe_n,
   input wire logic        sel_n_i,
   input wire logic        sel_n_oe_n,
   input wire logic        sel_pin_routed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // Data out and clock are both driven exactly when the port masters
   AST_MASTER_DRIVES: assert property (mosi_oe_n == sck_oe_n)
      else $error("data out and clock drive disagree");
   // Return data is driven only by a slave, never together with master pins
   AST_SLAVE_DRIVES: assert property (!miso_oe_n |-> mosi_oe_n && sck_oe_n)
      else $error("return data driven while mastering");
   // Select driven as output only when it is routed to a pin
   AST_SEL_OUT_ROUTED: assert property (!sel_n_oe_n |-> sel_pin_routed)
      else $error("select driven but not routed");
   // Six cycles of high select cover the input synchroniser and the pin register
   AST_UNSEL_RELEASE: assert property (sel_pin_routed && sel_n_oe_n && sel_n_i [*6] |-> miso_oe_n)
      else $error("return data driven while not selected");
   // A falling select input takes the master off the bus within a short bound
   AST_FAULT_RELEASE: assert property (!sck_oe_n && sel_pin_routed && sel_n_oe_n && $fell(sel_n_i)
      |-> ##[1:8] sck_oe_n)
      else $error("master kept the clock after select fell");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before acceptance");
   AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted with a response pending");
   AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not one cycle after address");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before acceptance");
endmodule

bind spm_port spm_port_asserts i_spm_port_asserts (.clk_sys, .srst, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .mosi_oe_n, .miso_oe_n, .sck_oe_n, .sel_n_i, .sel_n_oe_n, .sel_pin_routed);

// [sim/spm_peer.sv]
// Far-side serial device: slave while the port masters, master while the port is a slave
`timescale 1ns/1ps
module spm_peer (
   input  wire logic slave_en,
   input  wire logic sck_w,
   input  wire logic mosi_w,
   input  wire logic miso_w,
   output logic      p_mosi,
   output logic      p_mosi_oe,
   output logic      p_miso,
   output logic      p_miso_oe,
   output logic      p_sck,
   output logic      p_sck_oe,
   output logic      p_sel_n
);
   logic [7:0] tx_s = 8'h00;
   logic [7:0] rx_s = 8'h00;
   initial begin
      {p_mosi, p_mosi_oe, p_sck, p_sck_oe} = 4'h0;
      p_sel_n = 1'b1;
   end
   // Slave role: line released unless enabled, shifter MSB on the line
   assign p_miso    = tx_s[7];
   assign p_miso_oe = slave_en;
   always @(posedge sck_w) if (slave_en) rx_s <= {rx_s[6:0], mosi_w};
   always @(negedge sck_w) if (slave_en) tx_s <= {tx_s[6:0], 1'b0};
   task automatic load(input logic [7:0] b);
      tx_s = b;
   endtask
   // Select pulse with no clock, as a rival master would give
   task automatic sel_pulse();
      p_sel_n = 1'b0;
      #200;
      p_sel_n = 1'b1;
      #200;
   endtask
   // Master role; the long low phase leaves room for the port's input synchroniser
   task automatic xfer(input logic [7:0] tx, input int nbits, input bit use_sel, output logic [7:0] rx);
      rx        = 8'h00;
      p_mosi    = tx[7];
      p_mosi_oe = 1'b1;
      p_sel_n   = !use_sel;
      #200;
      p_sck_oe  = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         p_sck  = 1'b1;
         rx     = {rx[6:0], miso_w};
         #80;
         p_sck  = 1'b0;
         tx     = {tx[6:0], 1'b0};
         p_mosi = tx[7];
         #120;
      end
      {p_sck_oe, p_mosi_oe} = 2'b00;
      p_sel_n = 1'b1;
      #200;
   endtask
endmodule

// [sim/tb_spm_port.sv]
// Testbench: register bus tasks and byte exchanges against the far-side model
`timescale 1ns/1ps
module tb_spm_port;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, d;
   logic        mosi_o, mosi_oe_n, miso_o, miso_oe_n, sck_o, sck_oe_n, sel_n_o, sel_n_oe_n, sel_pin_routed;
   logic        p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_sck, p_sck_oe, p_sel_n;
   logic        peer_slave = 1'b0;
   logic [7:0]  prx;
   logic [1:0]  mode_tab [3] = '{2'b00, 2'b10, 2'b11};
   logic [7:0]  tx_tab [3] = '{8'ha5, 8'h81, 8'h7e};
   logic [7:0]  peer_tab [3] = '{8'h3c, 8'hc3, 8'h18};
   int          n_errors = 0, num_checks = 0, cycles = 0;
   // Line levels: data lines pulled up, clock pulled down, when nobody drives
   wire mosi_i  = !mosi_oe_n ? mosi_o : (p_mosi_oe ? p_mosi : 1'b1);
   wire miso_i  = !miso_oe_n ? miso_o : (p_miso_oe ? p_miso : 1'b1);
   wire sck_i   = !sck_oe_n ? sck_o : (p_sck_oe ? p_sck : 1'b0);
   wire sel_n_i = !sel_n_oe_n ? sel_n_o : p_sel_n;

   always #12.5 clk_sys = ~clk_sys;

   spm_port i_spm_port (.clk_sys, .srst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mosi_i, .mosi_o,
      .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n, .sck_i, .sck_o, .sck_oe_n, .sel_n_i, .sel_n_o, .sel_n_oe_n,
      .sel_pin_routed);
   // The bench bus carries this one far-side device only, slave or master
   spm_peer i_spm_peer (.slave_en(peer_slave), .sck_w(sck_i), .mosi_w(mosi_i), .miso_w(miso_i), .p_mosi,
      .p_mosi_oe, .p_miso, .p_miso_oe, .p_sck, .p_sck_oe, .p_sel_n);

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      chk("rresp", {30'h0, (a > 8'h10) ? 2'b10 : 2'b00}, {30'h0, s_axi_rresp});
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask
   // Poll the status word; the global timeout bounds this
   task automatic wait_done();
      logic [31:0] v;
      v = 32'h0;
      while (v[spm_pkg::STAT_DONE_BIT] !== 1'b1) rd(spm_pkg::STAT_OFF, v);
   endtask

   // Hang guard: the whole sequence needs under a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         $display("ERROR timeout expected 0 seen %0d", cycles);
         tally_and_finish();
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      rd_chk("ctrl_rst", spm_pkg::CTRL_OFF, {28'h0, spm_pkg::CTRL_RST});
      rd_chk("clkdiv_rst", spm_pkg::CLKDIV_OFF, 32'h3);
      rd_chk("stat_rst", spm_pkg::STAT_OFF, 32'h0);
      rd_chk("unmapped", 8'h14, 32'h0);
      wr(8'h14, 32'h1, 2'b10);
      // Port as master in select modes 00, 10 and 11, far side as slave
      peer_slave <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         i_spm_peer.load(peer_tab[m]);
         wr(spm_pkg::CTRL_OFF, {28'h0, mode_tab[m], 2'b11}, 2'b00);
         repeat (3) @(posedge clk_sys);
         chk("routed", {31'h0, mode_tab[m] != 2'b00}, {31'h0, sel_pin_routed});
         chk("sel_oe_n", {31'h0, !mode_tab[m][1]}, {31'h0, sel_n_oe_n});
         if (mode_tab[m][1]) chk("sel_level", {31'h0, mode_tab[m][0]}, {31'h0, sel_n_o});
         chk("master_oe_n", 32'h1, {29'h0, mosi_oe_n, sck_oe_n, miso_oe_n});
         wr(spm_pkg::TXDATA_OFF, {24'h0, tx_tab[m]}, 2'b00);
         wait_done();
         chk("peer_rx", {24'h0, tx_tab[m]}, {24'h0, i_spm_peer.rx_s});
         rd_chk("rxdata", spm_pkg::RXDATA_OFF, {24'h0, peer_tab[m]});
         wr(spm_pkg::STAT_OFF, 32'h1, 2'b00);
         rd_chk("done_clr", spm_pkg::STAT_OFF, 32'h0);
      end
      // Four-line slave, selected then not selected
      peer_slave <= 1'b0;
      wr(spm_pkg::CTRL_OFF, 32'h5, 2'b00);
      wr(spm_pkg::TXDATA_OFF, 32'h96, 2'b00);
      i_spm_peer.xfer(8'h69, 8, 1'b1, prx);
      chk("slave_tx", 32'h96, {24'h0, prx});
      wait_done();
      rd_chk("slave_rx", spm_pkg::RXDATA_OFF, 32'h69);
      wr(spm_pkg::STAT_OFF, 32'h1, 2'b00);
      i_spm_peer.xfer(8'h33, 8, 1'b0, prx);
      chk("unsel_line", 32'hff, {24'h0, prx});
      rd(spm_pkg::STAT_OFF, d);
      chk("unsel_done", 32'h0, {31'h0, d[spm_pkg::STAT_DONE_BIT]});
      // Three-line slave counts itself selected with select high
      wr(spm_pkg::CTRL_OFF, 32'h1, 2'b00);
      wr(spm_pkg::TXDATA_OFF, 32'h5a, 2'b00);
      i_spm_peer.xfer(8'hc6, 8, 1'b0, prx);
      chk("wire3_tx", 32'h5a, {24'h0, prx});
      wait_done();
      rd_chk("wire3_rx", spm_pkg::RXDATA_OFF, 32'hc6);
      wr(spm_pkg::STAT_OFF, 32'h1, 2'b00);
      // Three-line slave ignores select falls: 3 bits then 5 bits make one byte
      i_spm_peer.xfer(8'ha0, 3, 1'b1, prx);
      i_spm_peer.xfer(8'h68, 5, 1'b1, prx);
      wait_done();
      rd_chk("wire3_nosel", spm_pkg::RXDATA_OFF, 32'had);
      wr(spm_pkg::STAT_OFF, 32'h1, 2'b00);
      // Aborted partial byte; the next select fall must restart the count
      wr(spm_pkg::CTRL_OFF, 32'h5, 2'b00);
      i_spm_peer.xfer(8'he0, 3, 1'b1, prx);
      rd(spm_pkg::STAT_OFF, d);
      chk("partial_done", 32'h0, {31'h0, d[spm_pkg::STAT_DONE_BIT]});
      i_spm_peer.xfer(8'h4b, 8, 1'b1, prx);
      wait_done();
      rd_chk("resync_rx", spm_pkg::RXDATA_OFF, 32'h4b);
      // Rival master pulls select low while the port masters in mode 01
      wr(spm_pkg::CTRL_OFF, 32'h7, 2'b00);
      repeat (3) @(posedge clk_sys);
      i_spm_peer.sel_pulse();
      rd_chk("fault_ctrl", spm_pkg::CTRL_OFF, 32'h4);
      rd(spm_pkg::STAT_OFF, d);
      chk("fault_flag", 32'h1, {31'h0, d[spm_pkg::STAT_FAULT_BIT]});
      chk("fault_pins", 32'h3, {30'h0, mosi_oe_n, sck_oe_n});
      tally_and_finish();
   end
endmodule
